// ===== verilog/rsrc_pkg.sv
/*
  rsrc_pkg: constants shared by the reset-source and recovery-counter block,
  its recovery counter and its interrupt stacking sequencer.
  Assumes one 40 MHz core clock; every delay below is in source-clock falls.
*/
package rsrc_pkg;

  // recovery counter geometry
  localparam int          CTR_W          = 12;
  localparam logic [11:0] CTR_ZERO       = 12'h000;
  localparam int          SVC_LO_BIT     = 4;     // stages 12..5 are bits 11..4

  // recovery delays, in source-clock falls
  localparam int          LONG_DELAY     = 4096;
  localparam int          TAIL_DELAY     = 64;
  localparam int          SHORT_DELAY    = 32;
  localparam logic [11:0] LONG_LAST      = 12'(LONG_DELAY - 1);
  localparam logic [11:0] TAIL_LAST      = 12'(TAIL_DELAY - 1);
  localparam logic [11:0] SHORT_LAST     = 12'(SHORT_DELAY - 1);

  // reset cause register bit positions
  localparam int          CAUSE_POR      = 7;
  localparam int          CAUSE_COP      = 5;
  localparam int          CAUSE_ILLEGAL_OPCODE_FLAG     = 4;
  localparam int          CAUSE_ILLEGAL_ADDRESS_FLAG     = 3;
  localparam int          CAUSE_ERASED_VECTOR_RESET   = 2;
  localparam int          CAUSE_LVI      = 1;
  localparam logic [7:0]  CAUSE_RESET    = 8'h80;
  localparam logic [7:0]  CAUSE_NONE     = 8'h00;

  // erased flash byte seen on a blank reset vector
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

  // interrupt mask position in the condition code byte
  localparam int          CCR_I_BIT      = 3;
  localparam int          STACK_WRITES   = 4;
  localparam logic [1:0]  LAST_SLOT      = 2'(STACK_WRITES - 1);
  localparam logic [15:0] ADDR_ONE       = 16'h0001;

  // reset and recovery sequencer states
  typedef enum logic [2:0]
  {
    RSRC_RUN      = 3'b000,
    RSRC_HOLD     = 3'b001,
    RSRC_COUNT    = 3'b010,
    RSRC_TAIL     = 3'b011,
    RSRC_STOP     = 3'b100,
    RSRC_STOP_REC = 3'b101
  } rsrc_state_type;

  // interrupt stacking states
  typedef enum logic [2:0]
  {
    RSRC_SQ_IDLE  = 3'b000,
    RSRC_SQ_DUMMY = 3'b001,
    RSRC_SQ_PUSH  = 3'b010,
    RSRC_SQ_VECH  = 3'b011,
    RSRC_SQ_VECL  = 3'b100,
    RSRC_SQ_FETCH = 3'b101,
    RSRC_SQ_POP   = 3'b110,
    RSRC_SQ_POPND = 3'b111
  } rsrc_seq_type;

endpackage

// ===== verilog/rsrc_recovery_counter.sv
/*
  rsrc_recovery_counter: 12-bit free-running recovery counter.
  Assumes tick is a one-cycle pulse per source-clock fall; clear beats tick.
*/
module rsrc_recovery_counter
  import rsrc_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // control
  input  wire logic             tick,
  input  wire logic             clear,
  input  wire logic             clear_upper,
  // state
  output logic [CTR_W-1:0]      count_q,
  output logic                  overflow_q
);

  // count value with bits 11..4 removed by a watchdog service write
  logic [CTR_W-1:0] svc_mask;  // keeps only the low stages
  assign svc_mask = {{(CTR_W-SVC_LO_BIT){1'b0}}, {SVC_LO_BIT{1'b1}}};

  // counter: advances once per fall, never stops outside a clear
  always_ff @(posedge core_clk)
  begin
    if (reset || clear)
      count_q <= CTR_ZERO;
    else if (clear_upper)
      count_q <= count_q & svc_mask;
    else if (tick)
      count_q <= count_q + 12'h001;
  end

  // overflow pulse: one cycle when the counter wraps, prescaled watchdog clock
  always_ff @(posedge core_clk)
  begin
    if (reset || clear || clear_upper)
      overflow_q <= 1'b0;
    else
      overflow_q <= tick && (count_q == LONG_LAST);
  end

endmodule

// ===== verilog/rsrc_int_stacker.sv
/*
  rsrc_int_stacker: bus sequence for interrupt entry and return.
  Assumes a single-cycle bus: read data belongs to the address on the bus
  in the same cycle. Abort (internal reset) returns it to idle at once.
*/
module rsrc_int_stacker
  import rsrc_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             abort,
  // requests
  input  wire logic             irq_take,
  input  wire logic             rti_take,
  input  wire logic [15:0]      vector_addr,
  // cpu registers
  input  wire logic [15:0]      cpu_pc,
  input  wire logic [15:0]      cpu_sp,
  input  wire logic [7:0]       cpu_acc,
  input  wire logic [7:0]       cpu_ccr,
  // bus
  input  wire logic [7:0]       bus_rdata,
  output logic [15:0]           bus_addr_q,
  output logic [7:0]            bus_wdata_q,
  output logic                  bus_write_q,
  output logic                  bus_read_q,
  // results
  output logic                  irq_mask_q,
  output logic                  busy_q,
  output logic [15:0]           new_pc_q,
  output logic [15:0]           new_sp_q,
  output logic [7:0]            new_acc_q,
  output logic [7:0]            new_ccr_q
);

  rsrc_seq_type     state_q;    // sequence position
  logic [1:0]       slot_q;     // stack slot index
  logic [15:0]      sp_q;       // stack pointer at start
  logic [7:0]       save_q [STACK_WRITES];  // bytes to push
  logic [7:0]       vec_hi_q;   // vector high byte

  // sequence: dummy, four pushes, vector high/low, first opcode fetch
  always_ff @(posedge core_clk)
  begin
    if (reset || abort)
    begin
      state_q     <= RSRC_SQ_IDLE;
      slot_q      <= 2'b00;
      bus_write_q <= 1'b0;
      bus_read_q  <= 1'b0;
      busy_q      <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        RSRC_SQ_IDLE:
        begin
          bus_write_q <= 1'b0;
          bus_read_q  <= 1'b0;
          slot_q      <= 2'b00;
          if (irq_take)
          begin
            state_q    <= RSRC_SQ_DUMMY;
            busy_q     <= 1'b1;
            sp_q       <= cpu_sp;
            save_q[0]  <= cpu_pc[7:0];
            save_q[1]  <= cpu_pc[15:8];
            save_q[2]  <= cpu_acc;
            save_q[3]  <= cpu_ccr;
            bus_addr_q <= cpu_sp;
          end
          else if (rti_take)
          begin
            state_q    <= RSRC_SQ_POP;
            busy_q     <= 1'b1;
            sp_q       <= cpu_sp;
            bus_read_q <= 1'b1;
            bus_addr_q <= cpu_sp + ADDR_ONE;
          end
          else
            busy_q <= 1'b0;
        end
        RSRC_SQ_DUMMY:
        begin
          state_q     <= RSRC_SQ_PUSH;
          bus_write_q <= 1'b1;
          bus_addr_q  <= sp_q - ADDR_ONE;
          bus_wdata_q <= save_q[0];
        end
        RSRC_SQ_PUSH:
        begin
          // descending stack writes, one byte per cycle
          if (slot_q == LAST_SLOT)
          begin
            state_q     <= RSRC_SQ_VECH;
            bus_write_q <= 1'b0;
            bus_read_q  <= 1'b1;
            bus_addr_q  <= vector_addr;
          end
          else
          begin
            slot_q      <= slot_q + 2'b01;
            bus_addr_q  <= bus_addr_q - ADDR_ONE;
            bus_wdata_q <= save_q[slot_q + 2'b01];
          end
        end
        RSRC_SQ_VECH:
        begin
          state_q    <= RSRC_SQ_VECL;
          vec_hi_q   <= bus_rdata;
          bus_addr_q <= vector_addr + ADDR_ONE;
        end
        RSRC_SQ_VECL:
        begin
          state_q    <= RSRC_SQ_FETCH;
          bus_addr_q <= {vec_hi_q, bus_rdata};
        end
        RSRC_SQ_FETCH:
        begin
          state_q    <= RSRC_SQ_IDLE;
          bus_read_q <= 1'b0;
          busy_q     <= 1'b0;
        end
        RSRC_SQ_POP:
        begin
          if (slot_q == LAST_SLOT)
          begin
            state_q    <= RSRC_SQ_POPND;
            bus_read_q <= 1'b0;
          end
          else
          begin
            slot_q     <= slot_q + 2'b01;
            bus_addr_q <= bus_addr_q + ADDR_ONE;
          end
        end
        RSRC_SQ_POPND:
        begin
          state_q <= RSRC_SQ_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // register results: mask set on entry, restored state on return
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_mask_q <= 1'b1;
      new_pc_q   <= 16'h0000;
      new_sp_q   <= 16'h0000;
      new_acc_q  <= 8'h00;
      new_ccr_q  <= 8'h00;
    end
    else if (state_q == RSRC_SQ_DUMMY)
    begin
      irq_mask_q <= 1'b1;
      new_sp_q   <= sp_q - {14'h0000, LAST_SLOT} - ADDR_ONE;
    end
    else if (state_q == RSRC_SQ_FETCH)
      new_pc_q <= bus_addr_q;
    else if (state_q == RSRC_SQ_POP)
    begin
      // pops come back in reverse push order: ccr, acc, pc high, pc low
      unique case (slot_q)
        2'b00: new_ccr_q <= bus_rdata;
        2'b01: new_acc_q <= bus_rdata;
        2'b10: new_pc_q[15:8] <= bus_rdata;
        2'b11: new_pc_q[7:0] <= bus_rdata;
      endcase
      if (slot_q == 2'b00)
        irq_mask_q <= bus_rdata[CCR_I_BIT];
      new_sp_q <= sp_q + {14'h0000, LAST_SLOT} + ADDR_ONE;
    end
  end

endmodule

// ===== verilog/rsrc_reset_unit.sv
/*
  rsrc_reset_unit: reset causes, internal reset, recovery timing and
  interrupt stacking of the system integration unit.
  Assumes all inputs are synchronous to core_clk and that the selected
  source clock is sampled as a level, no faster than core_clk / 2.
*/
module rsrc_reset_unit
  import rsrc_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // reset sources
  input  wire logic             power_on_reset_pulse,
  input  wire logic             illegal_opcode_detect,
  input  wire logic             stop_exec,
  input  wire logic             opcode_fetch,
  input  wire logic             unmapped_access,
  input  wire logic             vector_fetch,
  input  wire logic [7:0]       vector_data,
  input  wire logic             low_voltage_detect,
  input  wire logic             watchdog_timeout,
  input  wire logic             watchdog_service_write,
  // option_config_register bits
  input  wire logic             stop_enable,
  input  wire logic             undervoltage_power_disable,
  input  wire logic             undervoltage_reset_disable,
  input  wire logic             short_stop_recovery,
  // stop exit and source clock
  input  wire logic             stop_exit_event,
  input  wire logic             selected_source_clock,
  // interrupt requests and cpu registers
  input  wire logic             irq_take,
  input  wire logic             rti_take,
  input  wire logic [15:0]      vector_addr,
  input  wire logic [15:0]      cpu_pc,
  input  wire logic [15:0]      cpu_sp,
  input  wire logic [7:0]       cpu_acc,
  input  wire logic [7:0]       cpu_ccr,
  input  wire logic [7:0]       bus_rdata,
  // reset and clock status
  output logic [7:0]            reset_cause_register,
  output logic                  internal_reset_q,
  output logic                  internal_bus_clock_en_q,
  output logic                  clk_gen_enable_q,
  output logic                  monitor_mode_q,
  output logic                  watchdog_clock_q,
  output logic [CTR_W-1:0]      recovery_count_q,
  // interrupt bus and results
  output logic [15:0]           bus_addr_q,
  output logic [7:0]            bus_wdata_q,
  output logic                  bus_write_q,
  output logic                  bus_read_q,
  output logic                  irq_mask_q,
  output logic                  stack_busy_q,
  output logic [15:0]           new_pc_q,
  output logic [15:0]           new_sp_q,
  output logic [7:0]            new_acc_q,
  output logic [7:0]            new_ccr_q
);

  rsrc_state_type   state_q;      // reset and recovery position
  rsrc_state_type   state_d;      // next position
  logic [7:0]       cause_q;      // reset_cause_register contents
  logic             src_q;        // source clock one cycle ago
  logic             tick;         // one pulse per source clock fall
  logic             ctr_clear;    // counter clear request
  logic             short_stop_recovery_q;      // short recovery sampled at stop exit
  logic [11:0]      stop_last;    // last count of the stop delay
  logic             ev_illegal_opcode_flag;      // illegal opcode, incl. disabled stop
  logic             ev_illegal_address_flag;      // opcode fetch from an unmapped address
  logic             ev_erased_vector_reset;    // erased reset vector byte
  logic             ev_lvi;       // gated undervoltage
  logic             ev_short;     // reset that skips the long count
  logic             ev_any;       // any reset source this cycle
  logic [7:0]       cause_set;    // flags raised this cycle
  logic             por_seen_q;   // power-on pulse went past

  assign reset_cause_register = cause_q;

  // event decode
  assign ev_illegal_opcode_flag   = illegal_opcode_detect || (stop_exec && !stop_enable);
  assign ev_illegal_address_flag   = opcode_fetch && unmapped_access;
  assign ev_erased_vector_reset = vector_fetch && (vector_data == ERASED_BYTE);
  assign ev_lvi    = low_voltage_detect && !undervoltage_power_disable
                     && !undervoltage_reset_disable;
  assign ev_short  = ev_illegal_opcode_flag || ev_illegal_address_flag || ev_erased_vector_reset || watchdog_timeout;
  assign ev_any    = power_on_reset_pulse || ev_lvi || ev_short;

  // falling edge of the source clock; input is already synchronous
  always_ff @(posedge core_clk)
  begin
    if (reset)
      src_q <= 1'b0;
    else
      src_q <= selected_source_clock;
  end
  assign tick = src_q && !selected_source_clock;

  assign stop_last = short_stop_recovery_q ? SHORT_LAST : LONG_LAST;

  // next recovery state; reset sources always beat stop and interrupts
  always_comb
  begin
    state_d   = state_q;
    ctr_clear = 1'b0;
    if (ev_any)
    begin
      ctr_clear = 1'b1;
      if (ev_lvi)
        state_d = RSRC_HOLD;
      else if (power_on_reset_pulse)
        state_d = RSRC_COUNT;
      else
        state_d = RSRC_TAIL;
    end
    else
    begin
      unique case (state_q)
        RSRC_RUN:
          if (stop_exec && stop_enable)
          begin
            state_d   = RSRC_STOP;
            ctr_clear = 1'b1;
          end
        RSRC_HOLD:
        begin
          // counter starts only once the supply is back
          ctr_clear = 1'b1;
          if (!low_voltage_detect)
            state_d = RSRC_COUNT;
        end
        RSRC_COUNT:
          if (tick && (recovery_count_q == LONG_LAST))
            state_d = RSRC_TAIL;
        RSRC_TAIL:
          if (tick && (recovery_count_q == TAIL_LAST))
            state_d = RSRC_RUN;
        RSRC_STOP:
          if (stop_exit_event)
          begin
            state_d   = RSRC_STOP_REC;
            ctr_clear = 1'b1;
          end
        RSRC_STOP_REC:
          if (tick && (recovery_count_q == stop_last))
            state_d = RSRC_RUN;
        default:
          state_d = RSRC_COUNT;  // unused codes recover through reset
      endcase
    end
  end

  // state and outputs that follow it
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q                 <= RSRC_COUNT;
      internal_reset_q        <= 1'b1;
      internal_bus_clock_en_q <= 1'b0;
    end
    else
    begin
      state_q                 <= state_d;
      internal_reset_q        <= (state_d == RSRC_HOLD) || (state_d == RSRC_COUNT)
                                 || (state_d == RSRC_TAIL);
      internal_bus_clock_en_q <= (state_d == RSRC_RUN);
    end
  end

  // short recovery bit sampled at the moment stop is left
  always_ff @(posedge core_clk)
  begin
    if (reset)
      short_stop_recovery_q <= 1'b0;
    else if (state_q == RSRC_STOP && stop_exit_event)
      short_stop_recovery_q <= short_stop_recovery;
  end

  // flags raised this cycle
  always_comb
  begin
    cause_set               = CAUSE_NONE;
    cause_set[CAUSE_POR]    = power_on_reset_pulse;
    cause_set[CAUSE_COP]    = watchdog_timeout;
    cause_set[CAUSE_ILLEGAL_OPCODE_FLAG]   = ev_illegal_opcode_flag;
    cause_set[CAUSE_ILLEGAL_ADDRESS_FLAG]   = ev_illegal_address_flag;
    cause_set[CAUSE_ERASED_VECTOR_RESET] = ev_erased_vector_reset;
    cause_set[CAUSE_LVI]    = ev_lvi;
  end

  // cause flags: any reset source, not only power-on, wipes older causes, but a same-cycle cause stays
  always_ff @(posedge core_clk)
  begin
    if (reset)
      cause_q <= CAUSE_RESET;
    else if (power_on_reset_pulse)
      cause_q <= cause_set;
    else if (ev_any)
      cause_q <= cause_set;
    // otherwise held for software to read
  end

  // monitor mode decided when the reset phase ends
  always_ff @(posedge core_clk)
  begin
    if (reset || power_on_reset_pulse)
      monitor_mode_q <= 1'b0;
    else if (state_q == RSRC_TAIL && state_d == RSRC_RUN)
      monitor_mode_q <= cause_q[CAUSE_ERASED_VECTOR_RESET];
  end

  // clock generator output enabled once the power-on pulse has passed
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      // the reset input stands for a power-on, so count it as a seen pulse
      por_seen_q       <= 1'b1;
      clk_gen_enable_q <= 1'b0;
    end
    else
    begin
      por_seen_q       <= por_seen_q || power_on_reset_pulse;
      clk_gen_enable_q <= por_seen_q && !power_on_reset_pulse;
    end
  end

  // recovery counter, also the watchdog prescaler
  rsrc_recovery_counter u_counter
  (
    .core_clk    (core_clk),
    .reset       (reset),
    .tick        (tick),
    .clear       (ctr_clear),
    .clear_upper (watchdog_service_write),
    .count_q     (recovery_count_q),
    .overflow_q  (watchdog_clock_q)
  );

  // interrupt entry and return; a reset aborts any sequence in flight
  rsrc_int_stacker u_stacker
  (
    .core_clk    (core_clk),
    .reset       (reset),
    .abort       (internal_reset_q),
    .irq_take    (irq_take),
    .rti_take    (rti_take),
    .vector_addr (vector_addr),
    .cpu_pc      (cpu_pc),
    .cpu_sp      (cpu_sp),
    .cpu_acc     (cpu_acc),
    .cpu_ccr     (cpu_ccr),
    .bus_rdata   (bus_rdata),
    .bus_addr_q  (bus_addr_q),
    .bus_wdata_q (bus_wdata_q),
    .bus_write_q (bus_write_q),
    .bus_read_q  (bus_read_q),
    .irq_mask_q  (irq_mask_q),
    .busy_q      (stack_busy_q),
    .new_pc_q    (new_pc_q),
    .new_sp_q    (new_sp_q),
    .new_acc_q   (new_acc_q),
    .new_ccr_q   (new_ccr_q)
  );

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_illegal_opcode_flag_sets_flag: assert property (ev_illegal_opcode_flag |=> cause_q[CAUSE_ILLEGAL_OPCODE_FLAG] && internal_reset_q)
    else $error("illegal opcode did not flag and reset");
  a_stop_off_illegal_opcode_flag: assert property ((stop_exec && !stop_enable) |=> cause_q[CAUSE_ILLEGAL_OPCODE_FLAG])
    else $error("disabled stop did not raise illegal opcode");
  a_illegal_address_flag_on_fetch: assert property (ev_illegal_address_flag |=> cause_q[CAUSE_ILLEGAL_ADDRESS_FLAG] && !internal_bus_clock_en_q)
    else $error("illegal address fetch not handled");
  a_data_read_quiet: assert property ((unmapped_access && !opcode_fetch && !power_on_reset_pulse)
                                      |=> cause_q[CAUSE_ILLEGAL_ADDRESS_FLAG] == $past(cause_q[CAUSE_ILLEGAL_ADDRESS_FLAG]))
    else $error("data read changed illegal address flag");
  a_erased_vector: assert property (ev_erased_vector_reset |=> cause_q[CAUSE_ERASED_VECTOR_RESET] && internal_reset_q)
    else $error("erased vector did not reset");
  a_lvi_gated: assert property ((low_voltage_detect && !ev_lvi && !power_on_reset_pulse)
                                |=> cause_q[CAUSE_LVI] == $past(cause_q[CAUSE_LVI]))
    else $error("disabled undervoltage changed its flag");
  a_por_clears_rest: assert property ((power_on_reset_pulse && !ev_lvi && !ev_short)
                                      |=> cause_q == CAUSE_RESET)
    else $error("power-on did not leave only its flag");
  a_stop_clears_ctr: assert property ((state_q == RSRC_RUN && stop_exec && stop_enable && !ev_any)
                                      |=> recovery_count_q == CTR_ZERO)
    else $error("stop did not clear the counter");
  a_service_upper: assert property ((watchdog_service_write && !ctr_clear)
                                    |=> recovery_count_q[11:SVC_LO_BIT] == 8'h00)
    else $error("service write left upper stages");
  a_short_recovery: assert property ((state_q == RSRC_STOP_REC && short_stop_recovery_q && tick
                                      && recovery_count_q == SHORT_LAST && !ev_any)
                                     |=> internal_bus_clock_en_q)
    else $error("short stop recovery did not release bus clocks");
  a_entry_push: assert property ((state_q == RSRC_RUN && !ev_any && irq_take && !stack_busy_q)
                                 ##1 !internal_reset_q |=> bus_write_q [*4] ##1 bus_read_q)
    else $error("interrupt entry bus order wrong");

  c_lvi_recovery: cover property (state_q == RSRC_HOLD ##1 state_q == RSRC_COUNT);
  c_stop_recovery: cover property (state_q == RSRC_STOP_REC ##1 state_q == RSRC_RUN);
  c_monitor_entry: cover property ($rose(monitor_mode_q));
  c_interrupt_entry: cover property ($rose(bus_write_q));

endmodule

// ===== testbench/rsrc_mem_model.sv
/*
  rsrc_mem_model: byte memory behind the stacking bus.
  Assumes single-cycle reads, data valid with the address.
*/
module rsrc_mem_model
(
  // bus
  input  wire logic        bus_read_q,
  input  wire logic [15:0] bus_addr_q,
  output logic [7:0]       bus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus shows the inverted high address byte so a stale byte never matches
  assign bus_rdata = bus_read_q ? bus_addr_q[7:0] ^ 8'h5A : ~bus_addr_q[15:8];
endmodule

// ===== testbench/testbench.sv
/*
  testbench: scenario tasks for rsrc_reset_unit.
  Assumes a fast source clock, one fall per two core cycles.
*/
module testbench
  import rsrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, reset = 1, selected_source_clock = 0, power_on_reset_pulse = 1;
  logic illegal_opcode_detect = 0, stop_exec = 0, opcode_fetch = 0, unmapped_access = 0;
  logic vector_fetch = 0, low_voltage_detect = 0, watchdog_timeout = 0;
  logic watchdog_service_write = 0, stop_enable = 0, undervoltage_power_disable = 0;
  logic undervoltage_reset_disable = 0, short_stop_recovery = 0, stop_exit_event = 0;
  logic irq_take = 0, rti_take = 0, internal_reset_q, internal_bus_clock_en_q;
  logic clk_gen_enable_q, monitor_mode_q, watchdog_clock_q, bus_write_q, bus_read_q;
  logic irq_mask_q, stack_busy_q;
  logic [7:0]  vector_data = 8'h00, cpu_acc = 8'h56, cpu_ccr = 8'h00, bus_rdata;
  logic [7:0]  reset_cause_register, bus_wdata_q, new_acc_q, new_ccr_q;
  logic [15:0] vector_addr = 16'hFFF0, cpu_pc = 16'h1234, cpu_sp = 16'h0080;
  logic [15:0] bus_addr_q, new_pc_q, new_sp_q;
  logic [11:0] recovery_count_q;
  logic [15:0] ea [8] = '{16'h0080, 16'h007F, 16'h007E, 16'h007D, 16'h007C, 16'hFFF0,
                          16'hFFF1, 16'hAAAB};
  logic [7:0]  ed [4] = '{8'h34, 8'h12, 8'h56, 8'h00};
  int          failures = 0;
  int          checks = 0;
  rsrc_reset_unit dut (.*);
  rsrc_mem_model mem (.*);
  always #12.5 core_clk = ~core_clk;
  // fastest legal source clock
  always @(posedge core_clk) #2 selected_source_clock = ~selected_source_clock;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // bounded wait on the internal reset level
  task automatic wait_rst(logic v, int lim);
    for (int i = 0; i < lim && internal_reset_q !== v; i++) cyc(1);
    chk("internal_reset_q", v, internal_reset_q);
  endtask
  // one-shot reset source, short 64-fall tail
  task automatic hit(string n, int b);
    cyc(1);
    {stop_exec, opcode_fetch, unmapped_access, vector_fetch, watchdog_timeout} = '0;
    wait_rst(1, 4);
    chk(n, 1, reset_cause_register[b]);
    chk("count", 0, recovery_count_q);
    wait_rst(0, 200);
    $display("test %s done", n);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #1ms;
    failures++;
    final_report();
  end
  initial
  begin
    cyc(12);
    {reset, power_on_reset_pulse} = '0;
    chk("cause", CAUSE_RESET, reset_cause_register);
    cyc(8000);
    chk("irst", 1, internal_reset_q);
    wait_rst(0, 400);
    chk("bus_en", 1, internal_bus_clock_en_q);
    chk("clkgen", 1, clk_gen_enable_q);
    irq_take = 1;
    cyc(1);
    irq_take = 0;
    foreach (ea[i])
    begin
      chk("addr", ea[i], bus_addr_q);
      chk("write", i inside {[1:4]}, bus_write_q);
      if (i inside {[1:4]}) chk("wdata", ed[i-1], bus_wdata_q);
      if (i > 1) chk("mask", 1, irq_mask_q);
      cyc(1);
    end
    chk("new_pc", 16'hAAAB, new_pc_q);
    chk("busy", 0, stack_busy_q);
    // return pops ccr, acc, pc high, pc low from sp+1 upwards
    rti_take = 1;
    cyc(1);
    rti_take = 0;
    cyc(5);
    chk("rti_ccr", 16'h00DB, new_ccr_q);
    chk("rti_acc", 16'h00D8, new_acc_q);
    chk("rti_pc", 16'hD9DE, new_pc_q);
    chk("rti_sp", 16'h0084, new_sp_q);
    chk("rti_busy", 0, stack_busy_q);
    $display("test interrupt done");
    stop_exec = 1;
    hit("stop_off", CAUSE_ILLEGAL_OPCODE_FLAG);
    {opcode_fetch, unmapped_access} = '1;
    hit("illegal_address_flag", CAUSE_ILLEGAL_ADDRESS_FLAG);
    {vector_fetch, vector_data} = 9'h1FF;
    hit("erased", CAUSE_ERASED_VECTOR_RESET);
    chk("monitor", 1, monitor_mode_q);
    {undervoltage_reset_disable, low_voltage_detect, unmapped_access} = '1;
    cyc(20);
    chk("irst", 0, internal_reset_q);
    chk("illegal_address_flag", 0, reset_cause_register[CAUSE_ILLEGAL_ADDRESS_FLAG]);
    {undervoltage_reset_disable, unmapped_access} = '0;
    wait_rst(1, 4);
    cyc(30);
    chk("count", 0, recovery_count_q);
    low_voltage_detect = 0;
    wait_rst(0, 8600);
    {stop_enable, stop_exec} = '1;
    cyc(1);
    stop_exec = 0;
    cyc(1);
    chk("bus_en", 0, internal_bus_clock_en_q);
    chk("count", 1, recovery_count_q <= 1);
    {short_stop_recovery, stop_exit_event} = '1;
    cyc(1);
    stop_exit_event = 0;
    cyc(50);
    chk("bus_en", 0, internal_bus_clock_en_q);
    repeat (30) if (internal_bus_clock_en_q !== 1) cyc(1);
    chk("bus_en", 1, internal_bus_clock_en_q);
    $display("test stop done");
    // service write drops the upper stages of a running count
    watchdog_service_write = 1;
    cyc(1);
    watchdog_service_write = 0;
    chk("svc", 0, recovery_count_q[11:4]);
    // bounded wait for the wrap pulse that clocks the watchdog
    for (int i = 0; i < 8300 && watchdog_clock_q !== 1; i++) cyc(1);
    chk("wdclk", 1, watchdog_clock_q);
    chk("count", 0, recovery_count_q);
    watchdog_timeout = 1;
    hit("cop", CAUSE_COP);
    final_report();
  end
endmodule
